// [design/fhd_defs.svh]
// Offsets, field positions, reset values and sizes of the floppy host block
`ifndef FHD_DEFS_SVH
`define FHD_DEFS_SVH
`define FHD_ADDR_W 10
`define FHD_ADDR_OUTPUT 10'h3f2
`define FHD_ADDR_STATUS 10'h3f4
`define FHD_ADDR_DSR 10'h3f4
`define FHD_ADDR_DATA 10'h3f5
`define FHD_ADDR_INPUT 10'h3f7
`define FHD_ADDR_RATE_CTRL 10'h3f7
`define FHD_STATUS_REQUEST 7
`define FHD_STATUS_DIRECTION 6
`define FHD_STATUS_NONDMA 5
`define FHD_STATUS_BUSY 4
`define FHD_OUT_DMA_GATE 3
`define FHD_OUT_RUN 2
`define FHD_DSR_SOFT_RST 7
`define FHD_RATE_CTRL_PRECOMP 2
`define FHD_RATE_CTRL_MASK 8'h07
`define FHD_OUT_RESET 8'h04
`define FHD_RATE_RESET 2'h2
`define FHD_FIFO_DEPTH 16
`define FHD_FIFO_WIDTH 8
`define FHD_THRESH_W 4
`define FHD_FILL_BYTE 8'h00
`define FHD_BASIC_UNDRIVEN 8'h7f
`endif

// [design/fhd_pkg.sv]
// Types used by the controller end of the floppy host block and by the bench
package fhd_pkg;
  typedef enum logic [1:0] {
    fhd_mode_basic,
    fhd_mode_dual,
    fhd_mode_full
  } fhd_mode_t;
  typedef enum logic [1:0] {
    fhd_ph_idle,
    fhd_ph_command,
    fhd_ph_exec,
    fhd_ph_result
  } fhd_phase_t;
endpackage

// [design/fhd_bus_if.sv]
// Byte-wide I/O bus between host processor and floppy host block
`timescale 1ns/1ns
`include "fhd_defs.svh"
interface fhd_bus_if;
  logic [`FHD_ADDR_W-1:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rdata_oe_n;
  modport dev (
    input addr,
    input rd,
    input wr,
    input wdata,
    output rdata,
    output rdata_oe_n
  );
  modport host (
    output addr,
    output rd,
    output wr,
    output wdata,
    input rdata,
    input rdata_oe_n
  );
endinterface

// [design/fhd_device.sv]
// Controller end: data port with FIFO, status, input and rate registers
`timescale 1ns/1ns
`include "fhd_defs.svh"
module fhd_device #(
  parameter int DEPTH = `FHD_FIFO_DEPTH,
  parameter int WIDTH = `FHD_FIFO_WIDTH
) (
  input wire logic clock_in,
  input wire logic reset_in,
  fhd_bus_if.dev bus,
  input wire fhd_pkg::fhd_mode_t mode_in,
  input wire fhd_pkg::fhd_phase_t phase_in,
  input wire logic exec_start_in,
  input wire logic dir_read_in,
  input wire logic non_dma_in,
  input wire logic [1:0] drive_busy_in,
  input wire logic cfg_load_in,
  input wire logic cfg_fifo_en_in,
  input wire logic [`FHD_THRESH_W-1:0] cfg_thresh_in,
  input wire logic [WIDTH-1:0] core_rx_data_in,
  input wire logic core_rx_valid_in,
  output logic core_rx_ready_out,
  output logic [WIDTH-1:0] core_tx_data_out,
  output logic core_tx_valid_out,
  input wire logic core_tx_ready_in,
  input wire logic sector_done_in,
  input wire logic disk_change_cable_in,
  input wire logic force_change_en_in,
  input wire logic force_change_val_in,
  output logic xfer_abort_out,
  output logic overrun_out,
  output logic underrun_out,
  output logic fill_active_out,
  output logic service_req_out,
  output logic soft_reset_out,
  output logic [1:0] rate_select_bits_out,
  output logic precomp_off_flag_out,
  output logic dma_gate_enable_out,
  output logic density_select_out
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [CW-1:0] count, cap, threshold;
  logic fifo_en, fifo_on, full, empty, push, pop, flush, soft_rst;
  logic [WIDTH-1:0] push_data;
  logic [7:0] digital_output_reg, main_status_reg, next_rdata, next_oe_n;
  logic [1:0] rate_select_bits;
  logic precomp_off_flag, fill_active, overrun, underrun, in_exec;
  logic host_transfer_request, transfer_direction;
  logic disk_changed_flag, low_rate_indicator;
  logic host_data_wr, host_data_rd;

  // Hardware reset sets the run bit; clearing it, or a DSR soft reset write, parks the core
  assign soft_rst = ~digital_output_reg[`FHD_OUT_RUN] |
    (bus.wr && bus.addr == `FHD_ADDR_DSR &&
     bus.wdata[`FHD_DSR_SOFT_RST]);
  assign soft_reset_out = soft_rst;
  assign in_exec = phase_in == fhd_pkg::fhd_ph_exec;
  assign transfer_direction = dir_read_in;
  // FIFO acts only in execution; commands go one byte at a time
  assign fifo_on = fifo_en && in_exec;
  assign cap = fifo_on ? CW'(DEPTH) : CW'(1);
  assign full = count >= cap;
  assign empty = count == '0;
  assign flush = exec_start_in | soft_rst;

  // Request bit: a byte to read, or room to write
  assign host_transfer_request = transfer_direction ? ~empty : ~full;

  assign host_data_wr = bus.wr && bus.addr == `FHD_ADDR_DATA;
  assign host_data_rd = bus.rd && bus.addr == `FHD_ADDR_DATA;

  // Accesses against the request bit are dropped, never queued
  always_comb begin
    push = 1'b0;
    pop = 1'b0;
    push_data = core_rx_data_in;
    if (transfer_direction) begin
      push = core_rx_valid_in && !full;
      pop = host_data_rd && !empty;
    end else begin
      push = host_data_wr && !full;
      push_data = bus.wdata;
      pop = core_tx_ready_in && !empty && !fill_active;
    end
  end

  assign core_rx_ready_out = transfer_direction && !full;
  assign core_tx_valid_out = !transfer_direction && (!empty || fill_active);
  assign core_tx_data_out = fill_active ? `FHD_FILL_BYTE :
    mem[rd_ptr];

  assign overrun = in_exec && transfer_direction && core_rx_valid_in && full;
  assign underrun = in_exec && !transfer_direction && core_tx_ready_in &&
    empty && !fill_active;

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // Pending read bytes survive an overrun so the host can drain them
  always_ff @(posedge clock_in) begin
    if (reset_in || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= PW'((32'(wr_ptr) + 1) % DEPTH);
      end
      if (pop) begin
        rd_ptr <= PW'((32'(rd_ptr) + 1) % DEPTH);
      end
      if (push && !pop) begin
        count <= count + CW'(1);
      end else if (pop && !push) begin
        count <= count - CW'(1);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in || soft_rst) begin
      fifo_en <= 1'b0;
      threshold <= CW'(1);
    end else if (cfg_load_in) begin
      fifo_en <= cfg_fifo_en_in;
      threshold <= CW'(cfg_thresh_in) + CW'(1);
    end
  end

  // Threshold trades bus latency against risk of overrun
  always_ff @(posedge clock_in) begin
    if (reset_in || flush) begin
      service_req_out <= 1'b0;
    end else if (fifo_on) begin
      service_req_out <= transfer_direction ? (count >= threshold) :
        (CW'(DEPTH) - count >= threshold);
    end else begin
      service_req_out <= in_exec && host_transfer_request;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in || soft_rst || exec_start_in) begin
      fill_active <= 1'b0;
    end else if (underrun) begin
      fill_active <= 1'b1;
    end else if (sector_done_in) begin
      fill_active <= 1'b0;
    end
  end
  assign fill_active_out = fill_active;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      xfer_abort_out <= 1'b0;
      overrun_out <= 1'b0;
      underrun_out <= 1'b0;
    end else begin
      xfer_abort_out <= overrun || underrun;
      overrun_out <= overrun;
      underrun_out <= underrun;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      digital_output_reg <= `FHD_OUT_RESET;
    end else if (bus.wr && bus.addr == `FHD_ADDR_OUTPUT) begin
      digital_output_reg <= bus.wdata;
    end
  end
  assign dma_gate_enable_out = digital_output_reg[`FHD_OUT_DMA_GATE];

  // Only hardware reset touches rate and precomp; soft resets keep them
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rate_select_bits <= `FHD_RATE_RESET;
      precomp_off_flag <= 1'b0;
    end else if (bus.wr && bus.addr == `FHD_ADDR_RATE_CTRL) begin
      rate_select_bits <= bus.wdata[1:0];
      if (mode_in == fhd_pkg::fhd_mode_full) begin
        precomp_off_flag <= bus.wdata[`FHD_RATE_CTRL_PRECOMP];
      end
    end
  end
  assign rate_select_bits_out = rate_select_bits;
  assign precomp_off_flag_out = precomp_off_flag;

  // 250K and 300K are the low rates
  assign low_rate_indicator = rate_select_bits[1] ^ rate_select_bits[0];

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      density_select_out <= 1'b1;
    end else if (bus.wr && bus.addr == `FHD_ADDR_RATE_CTRL) begin
      density_select_out <= ~(bus.wdata[1] ^ bus.wdata[0]);
    end
  end

  assign disk_changed_flag = force_change_en_in ? force_change_val_in :
    ~disk_change_cable_in;

  assign main_status_reg = {host_transfer_request, transfer_direction,
    non_dma_in, phase_in != fhd_pkg::fhd_ph_idle, 2'h0, drive_busy_in};

  always_comb begin
    next_rdata = 8'h00;
    next_oe_n = 8'hff;
    if (bus.rd) begin
      next_oe_n = 8'h00;
      case (bus.addr)
        `FHD_ADDR_STATUS: next_rdata = main_status_reg;
        `FHD_ADDR_DATA: next_rdata = pop ? mem[rd_ptr] : 8'h00;
        `FHD_ADDR_INPUT: begin
          case (mode_in)
            fhd_pkg::fhd_mode_dual: next_rdata = {disk_changed_flag, 4'hf,
              rate_select_bits, low_rate_indicator};
            fhd_pkg::fhd_mode_full: next_rdata = {disk_changed_flag, 3'h0,
              digital_output_reg[`FHD_OUT_DMA_GATE], precomp_off_flag,
              rate_select_bits};
            default: begin
              next_rdata = {disk_changed_flag, 7'h00};
              next_oe_n = `FHD_BASIC_UNDRIVEN;
            end
          endcase
        end
        default: next_oe_n = 8'hff;
      endcase
    end
  end

  // Read answer is registered and driven for exactly one cycle
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      bus.rdata <= 8'h00;
      bus.rdata_oe_n <= 8'hff;
    end else begin
      bus.rdata <= next_rdata;
      bus.rdata_oe_n <= next_oe_n;
    end
  end
endmodule

// [design/fhd_host.sv]
// Host end: byte bus master that paces data port access on status
`timescale 1ns/1ns
`include "fhd_defs.svh"
module fhd_host (
  input wire logic clock_in,
  input wire logic reset_in,
  fhd_bus_if.host bus,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [`FHD_ADDR_W-1:0] req_addr_in,
  input wire logic [7:0] req_wdata_in,
  output logic req_ready_out,
  output logic done_out,
  output logic [7:0] rdata_out
);
  typedef enum logic [2:0] {
    st_idle,
    st_poll,
    st_poll_wait,
    st_access,
    st_acc_wait
  } fhd_host_state_t;

  fhd_host_state_t state;
  logic write_l;
  logic [`FHD_ADDR_W-1:0] addr_l;
  logic [7:0] wdata_l;
  logic [7:0] seen;
  logic status_ok;

  // Undriven lines float high on the bus
  assign seen = bus.rdata | bus.rdata_oe_n;
  // Wait until request is set and direction matches the access
  assign status_ok = seen[`FHD_STATUS_REQUEST] &&
    (seen[`FHD_STATUS_DIRECTION] == ~write_l);

  assign req_ready_out = state == st_idle;
  assign bus.addr = state == st_poll ? `FHD_ADDR_STATUS : addr_l;
  assign bus.rd = state == st_poll || (state == st_access && !write_l);
  assign bus.wr = state == st_access && write_l;
  assign bus.wdata = wdata_l;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (req_valid_in) begin
            state <= req_addr_in == `FHD_ADDR_DATA ? st_poll : st_access;
          end
        end
        st_poll: state <= st_poll_wait;
        st_poll_wait: state <= status_ok ? st_access : st_poll;
        st_access: state <= write_l ? st_idle : st_acc_wait;
        st_acc_wait: state <= st_idle;
        default: state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      write_l <= 1'b0;
      addr_l <= '0;
      wdata_l <= 8'h00;
    end else if (state == st_idle && req_valid_in) begin
      write_l <= req_write_in;
      addr_l <= req_addr_in;
      // Reserved bits of the rate control register always go out as zero
      wdata_l <= req_addr_in == `FHD_ADDR_RATE_CTRL ?
        (req_wdata_in & `FHD_RATE_CTRL_MASK) : req_wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      done_out <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      done_out <= (state == st_access && write_l) || state == st_acc_wait;
      if (state == st_acc_wait) begin
        rdata_out <= seen;
      end
    end
  end
endmodule

// [bench/fhd_bus_checker.sv]
// Concurrent checks on the byte bus joining host and device ends
`timescale 1ns/1ns
module fhd_bus_checker (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [9:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [7:0] rdata_oe_n
);
  logic [7:0] stat;
  logic poll_d;
  logic [3:0] since;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // Last status seen, so each data access is judged on what the host saw
  always_ff @(posedge clock_in) begin
    poll_d <= rd && addr == 10'h3f4;
    if (poll_d) begin
      stat <= rdata;
    end
  end
  // Saturates so a long idle spell cannot wrap back to a small count
  always_ff @(posedge clock_in) begin
    if (rd && addr == 10'h3f4) begin
      since <= 4'h0;
    end else if (since != 4'hf) begin
      since <= since + 4'h1;
    end
  end
  sequence s_data_rd;
    rd && addr == 10'h3f5;
  endsequence
  sequence s_data_wr;
    wr && addr == 10'h3f5;
  endsequence
  data_read_a: assert property (s_data_rd |=> rdata_oe_n == 8'h00)
    else $error("data port read not answered");
  status_read_a: assert property (
    rd && addr == 10'h3f4 |=> !rdata_oe_n)
    else $error("status read not answered");
  change_bit_a: assert property (
    rd && addr == 10'h3f7 |=> !rdata_oe_n[7])
    else $error("input register bit 7 not driven");
  idle_float_a: assert property (!rd |=> rdata_oe_n == 8'hff)
    else $error("bus driven without a read");
  unmapped_read_a: assert property (
    rd && addr[9:4] != 6'h3f |=> &rdata_oe_n)
    else $error("unmapped read drove the bus");
  poll_first_a: assert property (
    (s_data_rd or s_data_wr) |-> since < 4'h6)
    else $error("data access without recent status poll");
  write_gate_a: assert property (s_data_wr |-> stat[7] && !stat[6])
    else $error("data write against status");
  read_gate_a: assert property (s_data_rd |-> stat[7] && stat[6])
    else $error("data read against status");
  strobe_pulse_a: assert property (rd || wr |=> !(rd || wr))
    else $error("strobe longer than one cycle");
endmodule

// [bench/floppy_host_data_and_rate_regs_bench.sv]
// Bench joining host and device ends, driving both user sides
`timescale 1ns/1ns
module floppy_host_data_and_rate_regs_bench;
  logic clock_in = 0;
  logic reset_in = 1;
  fhd_pkg::fhd_mode_t mode = fhd_pkg::fhd_mode_full;
  fhd_pkg::fhd_phase_t phase = fhd_pkg::fhd_ph_idle;
  logic exs = 0, dird = 0, cld = 0, rxv = 0, txr = 0, sdone = 0;
  logic cable = 1, fen = 0, fval = 0, rv = 0, rw = 0;
  logic [7:0] rxd = 8'h00, rwd = 8'h00, txd, rdo, last_oe, last_tx;
  logic [9:0] ra = 10'h000;
  logic rxr, txv, abt, ovr, und, fill, sreq, dens, rrdy, done, pof, dge, srs;
  logic [1:0] rsb;
  int n_srs = 0;
  int err_count = 0, checked = 0, cycles = 0, n_ovr = 0, n_und = 0, n_abt = 0;
  fhd_bus_if i_fhd_bus_if ();
  fhd_device i_fhd_device (.clock_in(clock_in), .reset_in(reset_in),
    .bus(i_fhd_bus_if), .mode_in(mode), .phase_in(phase),
    .exec_start_in(exs), .dir_read_in(dird), .non_dma_in(1'b0),
    .drive_busy_in(2'h0), .cfg_load_in(cld), .cfg_fifo_en_in(1'b1),
    .cfg_thresh_in(4'h3), .core_rx_data_in(rxd), .core_rx_valid_in(rxv),
    .core_rx_ready_out(rxr), .core_tx_data_out(txd),
    .core_tx_valid_out(txv), .core_tx_ready_in(txr),
    .sector_done_in(sdone), .disk_change_cable_in(cable),
    .force_change_en_in(fen), .force_change_val_in(fval),
    .xfer_abort_out(abt), .overrun_out(ovr), .underrun_out(und),
    .fill_active_out(fill), .service_req_out(sreq), .soft_reset_out(srs),
    .rate_select_bits_out(rsb), .precomp_off_flag_out(pof),
    .dma_gate_enable_out(dge), .density_select_out(dens));
  fhd_host i_fhd_host (.clock_in(clock_in), .reset_in(reset_in),
    .bus(i_fhd_bus_if), .req_valid_in(rv), .req_write_in(rw),
    .req_addr_in(ra), .req_wdata_in(rwd), .req_ready_out(rrdy),
    .done_out(done), .rdata_out(rdo));
  fhd_bus_checker i_fhd_bus_checker (.clock_in(clock_in),
    .reset_in(reset_in), .addr(i_fhd_bus_if.addr), .rd(i_fhd_bus_if.rd),
    .wr(i_fhd_bus_if.wr), .wdata(i_fhd_bus_if.wdata),
    .rdata(i_fhd_bus_if.rdata), .rdata_oe_n(i_fhd_bus_if.rdata_oe_n));
  always #5 clock_in = ~clock_in;
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Pulses last one cycle, so they are counted here rather than polled
  always @(negedge clock_in) begin
    cycles++;
    n_ovr += ovr;
    n_und += und;
    n_abt += abt;
    n_srs += srs;
    if (txv && txr) last_tx = txd;
    if (i_fhd_bus_if.rdata_oe_n !== 8'hff) last_oe = i_fhd_bus_if.rdata_oe_n;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clock_in);
    while (rrdy !== 1'b1) @(negedge clock_in);
    rv = 1;
    rw = w;
    ra = a;
    rwd = d;
    @(negedge clock_in);
    rv = 0;
    while (done !== 1'b1 && n < 100) begin
      @(negedge clock_in);
      n++;
    end
    if (n == 100) err_count++;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e, input string n);
    acc(0, a, 8'h00);
    cmp(n, e, rdo);
  endtask
  // Holds the byte until the device takes it, as a real core would
  task automatic push(input logic [7:0] d);
    @(negedge clock_in);
    rxv = 1;
    rxd = d;
    while (rxr !== 1'b1) @(negedge clock_in);
    @(negedge clock_in);
    rxv = 0;
    rxd = ~d;
  endtask
  initial begin
    repeat (10) @(negedge clock_in);
    reset_in = 0;
    rdc(10'h3f7, 8'h02, "input reg reset");
    cmp("density reset", 8'h01, {7'h0, dens});
    $display("test reset done");
    acc(1, 10'h3f7, 8'h05);
    acc(1, 10'h3f2, 8'h0c);
    rdc(10'h3f7, 8'h0d, "full layout");
    mode = fhd_pkg::fhd_mode_dual;
    for (int r = 0; r < 4; r++) begin
      acc(1, 10'h3f7, 8'(r));
      rdc(10'h3f7, {5'h0f, 2'(r), 1'(r == 1 || r == 2)}, "dual");
      cmp("density", {7'h0, !(r == 1 || r == 2)}, {7'h0, dens});
    end
    mode = fhd_pkg::fhd_mode_basic;
    cable = 0;
    acc(0, 10'h3f7, 8'h00);
    cmp("basic change", 8'h01, {7'h0, rdo[7]});
    cmp("basic float", 8'h7f, last_oe);
    mode = fhd_pkg::fhd_mode_full;
    fen = 1;
    acc(1, 10'h3f7, 8'h05);
    rdc(10'h3f7, 8'h0d, "forced change");
    rdc(10'h100, 8'hff, "unmapped");
    $display("test layouts done");
    acc(1, 10'h3f4, 8'h80);
    acc(0, 10'h3f7, 8'h00);
    cmp("soft reset kept", 8'h05, rdo & 8'h07);
    cmp("density soft", 8'h00, {7'h0, dens});
    cmp("soft reset pulse", 8'h01, 8'(n_srs));
    cmp("rate pins", 8'h0d, {4'h0, dge, pof, rsb});
    @(negedge clock_in);
    reset_in = 1;
    repeat (10) @(negedge clock_in);
    reset_in = 0;
    rdc(10'h3f7, 8'h02, "hard reset");
    $display("test resets done");
    phase = fhd_pkg::fhd_ph_command;
    txr = 1;
    acc(1, 10'h3f5, 8'h3c);
    repeat (3) @(negedge clock_in);
    cmp("core byte", 8'h3c, last_tx);
    dird = 1;
    push(8'ha5);
    rdc(10'h3f5, 8'ha5, "host byte");
    $display("test single byte done");
    cld = 1;
    @(negedge clock_in);
    cld = 0;
    push(8'hee);
    exs = 1;
    phase = fhd_pkg::fhd_ph_exec;
    @(negedge clock_in);
    exs = 0;
    for (int i = 0; i < 16; i++) begin
      push(8'(i));
      if (i == 2) begin
        repeat (2) @(negedge clock_in);
        cmp("below threshold", 8'h00, {7'h0, sreq});
      end
    end
    repeat (2) @(negedge clock_in);
    cmp("service request", 8'h01, {7'h0, sreq});
    rxv = 1;
    @(negedge clock_in);
    rxv = 0;
    repeat (2) @(negedge clock_in);
    cmp("overrun", 8'h01, 8'(n_ovr));
    cmp("abort", 8'h01, 8'(n_abt));
    for (int i = 0; i < 16; i++) rdc(10'h3f5, 8'(i), "drain");
    dird = 0;
    repeat (3) @(negedge clock_in);
    cmp("underrun", 8'h01, 8'(n_und));
    cmp("fill", 8'h01, {7'h0, fill && txv});
    cmp("fill byte", 8'h00, txd);
    txr = 0;
    sdone = 1;
    @(negedge clock_in);
    sdone = 0;
    repeat (2) @(negedge clock_in);
    cmp("fill end", 8'h00, {7'h0, fill});
    $display("test fifo done");
    wrap_up();
  end
endmodule
